// ### verilog/asp_pkg.sv
// Constants and types shared by the asynchronous serial port.
// Assumes a 32-bit classic Wishbone bus with byte addresses, one word a register.
package asp_pkg;
  // Register byte addresses.
  localparam logic [7:0] OFS_CTRL_TWO   = 8'h00;
  localparam logic [7:0] OFS_STAT_ONE   = 8'h04;
  localparam logic [7:0] OFS_CTRL_THREE = 8'h08;
  localparam logic [7:0] OFS_CTRL_ONE   = 8'h0C;
  localparam logic [7:0] OFS_DATA       = 8'h10;
  localparam logic [7:0] OFS_BAUD       = 8'h14;
  // Control two fields.
  localparam int B_TX_EN = 3;
  localparam int B_RX_EN = 2;
  localparam int B_STBY  = 1;
  localparam int B_BRK   = 0;
  // Control three fields.
  localparam int B_SWDIR = 5;
  localparam int B_INV   = 4;
  localparam int B_OVERRUN_IRQ_EN  = 3;
  localparam int B_PARITY_IRQ_EN  = 0;
  // Control one fields.
  localparam int B_LOOP  = 7;
  localparam int B_SWSRC = 5;
  localparam int B_WAKE  = 3;
  localparam int B_LBRK  = 2;
  localparam int B_PEN   = 1;
  localparam int B_PODD  = 0;
  // Status one fields.
  localparam int S_TDRE  = 7;
  localparam int S_TC    = 6;
  localparam int S_RDRF  = 5;
  localparam int S_IDLE  = 4;
  localparam int S_OR    = 3;
  localparam int S_NF    = 2;
  localparam int S_FE    = 1;
  localparam int S_PF    = 0;
  // Reset values and the receive flag mask.
  localparam logic [7:0]  DATA_RESET = 8'h00;
  localparam logic [7:0]  STAT_RESET = 8'hC0;
  localparam logic [7:0]  RX_FLAGS   = 8'h3F;
  localparam logic [12:0] BAUD_RESET = 13'h0001;
  // Bit timing: sixteen ticks a bit, three middle samples.
  localparam logic [3:0]  OVS_LAST   = 4'hF;
  localparam logic [3:0]  SMP_FIRST  = 4'h7;
  localparam logic [3:0]  SMP_LAST   = 4'h9;
  localparam logic [3:0]  FRAME_BITS = 4'hA;
  localparam logic [3:0]  BRK_EXTRA  = 4'h3;
  // Control fields gathered from the three control registers.
  typedef struct packed {
    logic       tx_enable;
    logic       rx_enable;
    logic       rx_standby;
    logic       break_queue;
    logic       loop_select;
    logic       single_wire_source;
    logic       single_wire_direction;
    logic       long_break_select;
    logic       tx_polarity_flip;
    logic       wake_select;
    logic       parity_en;
    logic       parity_odd;
    logic [3:0] irq_en;
  } asp_ctrl_t;
  typedef enum {TX_IDLE, TX_SHIFT} asp_tx_state_t;
  typedef enum {RX_IDLE, RX_BITS} asp_rx_state_t;
endpackage : asp_pkg

// ### verilog/asp_baud.sv
// Shared baud generator giving one tick per sixteenth of a bit.
// Assumes the divisor comes from a register on the same bus-rate clock.
`timescale 1ns/1ps
module asp_baud (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [12:0] divisor_i,
  output logic             tick_o
);
  logic [12:0] cnt_reg;

  // Counts bus clocks and pulses once every divisor clocks; zero stops it.
  always_ff @(posedge clk_i) begin // [R21]
    if (rst_i) begin
      cnt_reg <= '0;
      tick_o  <= 1'b0;
    end else if (ce_i) begin
      if (divisor_i == '0) begin
        cnt_reg <= '0;
        tick_o  <= 1'b0;
      end else if (cnt_reg >= 13'(divisor_i - 13'h0001)) begin
        cnt_reg <= '0;
        tick_o  <= 1'b1;
      end else begin
        cnt_reg <= 13'(cnt_reg + 13'h0001);
        tick_o  <= 1'b0;
      end
    end
  end
endmodule : asp_baud

// ### verilog/asp_core.sv
// Asynchronous serial port: Wishbone registers, transmitter and receiver.
// Assumes a classic Wishbone master on clk_i and serial pins from outside.
// Summary of operation
// R01 - Transmitter runs and drives its pin while tx_enable is one or a frame is still running or queued.
// R02 - In single-wire mode the direction bit decides drive or receive.
// R03 - Re-enabling the transmitter during a frame queues one idle character.
// R04 - After disable the pin stays driven until queued frames finish.
// R05 - Receive pin is released when receiver is off or loop is set.
// R06 - Standby waits for idle line or a set top data bit.
// R07 - Software sets standby; hardware clears it on the wakeup.
// R08 - Break bit written one then zero queues a break; more while one.
// R09 - Break is 10 or 11 zero bits, 13 or 14 when long.
// R10 - A second break may be queued before the bit is cleared.
// R11 - Status register holds eight read-only flags; writes do nothing.
// R12 - All flags but TC clear only by sequences reading status then touching data.
// R13 - Polarity flip inverts every transmitted bit, break and idle included.
// R14 - Overrun flag requests an interrupt when its enable is one.
// R15 - Noise flag requests an interrupt when its enable is one.
// R16 - Framing flag requests an interrupt when its enable is one.
// R17 - Parity flag requests an interrupt when its enable is one.
// R18 - Data address reads receive buffer, writes transmit buffer, both reset zero.
// R19 - Full-duplex asynchronous NRZ traffic with a remote device.
// R20 - Transmitter and receiver run independently on one baud generator.
// R21 - The baud generator runs from the bus clock.
// R22 - Interrupt output is high while any enabled error flag is set.
`timescale 1ns/1ps
module asp_core (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rxd_i,
  input  wire logic        txd_i,
  output logic             txd_o,
  output logic             txd_oe_o,
  output logic             rxd_own_o,
  output logic             irq_o
);
  asp_pkg::asp_ctrl_t     ctrl_reg;
  asp_pkg::asp_tx_state_t tx_state_reg;
  asp_pkg::asp_rx_state_t rx_state_reg;
  logic [7:0]  stat_reg;
  logic [7:0]  stat_next;
  logic [12:0] baud_reg;
  logic [7:0]  tx_buf_reg;
  logic [7:0]  rx_buf_reg;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        tick;
  logic        rxd_s1_reg;
  logic        rxd_s2_reg;
  logic        txd_s1_reg;
  logic        txd_s2_reg;
  logic [10:0] tx_sh_reg;
  logic [3:0]  tx_ovs_reg;
  logic [3:0]  tx_left_reg;
  logic        tx_fill_reg;
  logic        tx_bit_reg;
  logic        brk_pend_reg;
  logic        idle_pend_reg;
  logic        tx_busy;
  logic        tx_active;
  logic        tx_start;
  logic        frame_brk;
  logic        single_wire;
  logic        rx_in;
  logic [3:0]  rx_ovs_reg;
  logic [3:0]  rx_idx_reg;
  logic [3:0]  rx_ones_reg;
  logic [2:0]  rx_smp_reg;
  logic [9:0]  rx_sh_reg;
  logic        rx_noise_reg;
  logic        rx_armed_reg;
  logic        rx_bit_end;
  logic        rx_end;
  logic        rx_take;
  logic        rx_maj;
  logic        rx_quiet;
  logic        idle_set;
  logic        wake_idle;
  logic        wake_mark;
  logic        arm_rx_reg;
  logic        arm_tx_reg;

  // Frame length in bit times, longer for parity and long breaks.
  function automatic logic [3:0] frame_len(input logic pen, input logic lng);
    frame_len = 4'(asp_pkg::FRAME_BITS + {3'h0, pen} + (lng ? asp_pkg::BRK_EXTRA : 4'h0));
  endfunction : frame_len

  // Address match for one register word.
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction : hit

  // Baud ticks feed both directions from one generator.
  asp_baud u_baud ( // [R20]
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .divisor_i (baud_reg),
    .tick_o    (tick)
  );

  // Bus decode: an access is taken once, in the cycle before ack.
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr  = acc & wb_we_i & wb_sel_i[0];
  assign rd  = acc & ~wb_we_i;

  // Acknowledge and read data; unmapped addresses answer zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_ack_o <= acc;
      wb_dat_o <= '0;
      if (rd) begin
        case (wb_adr_i)
          asp_pkg::OFS_CTRL_TWO:   wb_dat_o[3:0] <= {ctrl_reg.tx_enable, ctrl_reg.rx_enable,
                                                     ctrl_reg.rx_standby, ctrl_reg.break_queue};
          asp_pkg::OFS_STAT_ONE:   wb_dat_o[7:0] <= stat_reg;
          asp_pkg::OFS_CTRL_THREE: wb_dat_o[5:0] <= {ctrl_reg.single_wire_direction,
                                                     ctrl_reg.tx_polarity_flip, ctrl_reg.irq_en};
          asp_pkg::OFS_CTRL_ONE:   wb_dat_o[7:0] <= {ctrl_reg.loop_select, 1'b0,
                                                     ctrl_reg.single_wire_source, 1'b0,
                                                     ctrl_reg.wake_select, ctrl_reg.long_break_select,
                                                     ctrl_reg.parity_en, ctrl_reg.parity_odd};
          asp_pkg::OFS_DATA:       wb_dat_o[7:0] <= rx_buf_reg; // [R18]
          asp_pkg::OFS_BAUD:       wb_dat_o[12:0] <= baud_reg;
          default:                 wb_dat_o <= '0;
        endcase
      end
    end
  end

  // Control writes; hardware wakeup clears standby unless software writes it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= '0;
      baud_reg <= asp_pkg::BAUD_RESET;
    end else if (ce_i) begin
      if (wake_idle || wake_mark) begin
        ctrl_reg.rx_standby <= 1'b0; // [R07]
      end
      if (wr && hit(wb_adr_i, asp_pkg::OFS_CTRL_TWO)) begin
        ctrl_reg.tx_enable   <= wb_dat_i[asp_pkg::B_TX_EN]; // [R01]
        ctrl_reg.rx_enable   <= wb_dat_i[asp_pkg::B_RX_EN];
        ctrl_reg.rx_standby  <= wb_dat_i[asp_pkg::B_STBY]; // [R06]
        ctrl_reg.break_queue <= wb_dat_i[asp_pkg::B_BRK];
      end
      if (wr && hit(wb_adr_i, asp_pkg::OFS_CTRL_THREE)) begin
        ctrl_reg.single_wire_direction <= wb_dat_i[asp_pkg::B_SWDIR];
        ctrl_reg.tx_polarity_flip      <= wb_dat_i[asp_pkg::B_INV];
        ctrl_reg.irq_en                <= wb_dat_i[asp_pkg::B_OVERRUN_IRQ_EN:asp_pkg::B_PARITY_IRQ_EN];
      end
      if (wr && hit(wb_adr_i, asp_pkg::OFS_CTRL_ONE)) begin
        ctrl_reg.loop_select        <= wb_dat_i[asp_pkg::B_LOOP];
        ctrl_reg.single_wire_source <= wb_dat_i[asp_pkg::B_SWSRC];
        ctrl_reg.wake_select        <= wb_dat_i[asp_pkg::B_WAKE];
        ctrl_reg.long_break_select  <= wb_dat_i[asp_pkg::B_LBRK];
        ctrl_reg.parity_en          <= wb_dat_i[asp_pkg::B_PEN];
        ctrl_reg.parity_odd         <= wb_dat_i[asp_pkg::B_PODD];
      end
      if (acc && wb_we_i && hit(wb_adr_i, asp_pkg::OFS_BAUD)) begin
        if (wb_sel_i[0]) baud_reg[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) baud_reg[12:8] <= wb_dat_i[12:8];
      end
    end
  end

  // Two-stage synchronisers for both line inputs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxd_s1_reg <= 1'b1;
      rxd_s2_reg <= 1'b1;
      txd_s1_reg <= 1'b1;
      txd_s2_reg <= 1'b1;
    end else if (ce_i) begin
      rxd_s1_reg <= rxd_i;
      rxd_s2_reg <= rxd_s1_reg;
      txd_s1_reg <= txd_i;
      txd_s2_reg <= txd_s1_reg;
    end
  end

  // Transmit scheduling: break first, then queued idle, then buffered data.
  assign single_wire = ctrl_reg.loop_select & ctrl_reg.single_wire_source;
  assign tx_busy     = (tx_state_reg == asp_pkg::TX_SHIFT);
  assign tx_active   = ctrl_reg.tx_enable | tx_busy | brk_pend_reg | idle_pend_reg; // [R04]
  assign frame_brk   = (ctrl_reg.break_queue & ctrl_reg.tx_enable) | brk_pend_reg; // [R08] [R10]
  assign tx_start    = tick & ~tx_busy & (frame_brk | idle_pend_reg |
                       (ctrl_reg.tx_enable & ~stat_reg[asp_pkg::S_TDRE]));

  // Queued break and idle characters; a new request wins over its clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brk_pend_reg  <= 1'b0;
      idle_pend_reg <= 1'b0;
    end else if (ce_i) begin
      brk_pend_reg <= (brk_pend_reg & ~(tx_start & frame_brk)) |
                      (wr && hit(wb_adr_i, asp_pkg::OFS_CTRL_TWO) && ctrl_reg.break_queue &&
                       !wb_dat_i[asp_pkg::B_BRK]); // [R08]
      idle_pend_reg <= (idle_pend_reg & ~(tx_start & ~frame_brk)) |
                       (wr && hit(wb_adr_i, asp_pkg::OFS_CTRL_TWO) && tx_busy &&
                        !ctrl_reg.tx_enable && wb_dat_i[asp_pkg::B_TX_EN]); // [R03]
    end
  end

  // Transmit shifter, least significant bit first, sixteen ticks a bit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_reg <= asp_pkg::TX_IDLE;
      tx_sh_reg    <= '1;
      tx_ovs_reg   <= '0;
      tx_left_reg  <= '0;
      tx_fill_reg  <= 1'b1;
    end else if (ce_i) begin
      if (tx_start) begin
        tx_state_reg <= asp_pkg::TX_SHIFT;
        tx_ovs_reg   <= '0;
        if (frame_brk) begin
          tx_sh_reg   <= '0;
          tx_fill_reg <= 1'b0;
          tx_left_reg <= frame_len(ctrl_reg.parity_en, ctrl_reg.long_break_select); // [R09]
        end else begin
          tx_fill_reg <= 1'b1;
          tx_left_reg <= frame_len(ctrl_reg.parity_en, 1'b0);
          if (idle_pend_reg) begin
            tx_sh_reg <= '1;
          end else begin
            tx_sh_reg <= {1'b1, ~ctrl_reg.parity_en | (^tx_buf_reg ^ ctrl_reg.parity_odd),
                          tx_buf_reg, 1'b0}; // [R19]
          end
        end
      end else if (tx_busy && tick) begin
        tx_ovs_reg <= 4'(tx_ovs_reg + 4'h1);
        if (tx_ovs_reg == asp_pkg::OVS_LAST) begin
          tx_sh_reg   <= {tx_fill_reg, tx_sh_reg[10:1]};
          tx_left_reg <= 4'(tx_left_reg - 4'h1);
          if (tx_left_reg == 4'h1) begin
            tx_state_reg <= asp_pkg::TX_IDLE;
          end
        end
      end
    end
  end

  // Pin drivers: line level, inversion, enables and receive pin ownership.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_bit_reg <= 1'b1;
      txd_o      <= 1'b1;
      txd_oe_o   <= 1'b0;
      rxd_own_o  <= 1'b0;
    end else if (ce_i) begin
      tx_bit_reg <= tx_busy ? tx_sh_reg[0] : 1'b1;
      txd_o      <= (tx_busy ? tx_sh_reg[0] : 1'b1) ^ ctrl_reg.tx_polarity_flip; // [R13]
      txd_oe_o   <= tx_active & (~single_wire | ctrl_reg.single_wire_direction); // [R01] [R02]
      rxd_own_o  <= ctrl_reg.rx_enable & ~ctrl_reg.loop_select; // [R05]
    end
  end

  // Receive source: pin, the shared wire, or the internal loop.
  assign rx_in = ctrl_reg.loop_select ?
                 (ctrl_reg.single_wire_source ? txd_s2_reg : tx_bit_reg) : rxd_s2_reg;
  assign rx_maj = (rx_smp_reg[0] & rx_smp_reg[1]) | (rx_smp_reg[0] & rx_smp_reg[2]) |
                  (rx_smp_reg[1] & rx_smp_reg[2]);
  assign rx_bit_end = ce_i & tick & ctrl_reg.rx_enable & (rx_state_reg == asp_pkg::RX_BITS) &
                      (rx_ovs_reg == asp_pkg::OVS_LAST);
  assign rx_end  = rx_bit_end &
                   (rx_idx_reg == 4'(frame_len(ctrl_reg.parity_en, 1'b0) - 4'h1));
  assign rx_quiet = ce_i & tick & ctrl_reg.rx_enable & rx_in & rx_armed_reg &
                    (rx_state_reg == asp_pkg::RX_IDLE) & (rx_ovs_reg == asp_pkg::OVS_LAST) &
                    (rx_ones_reg == 4'(frame_len(ctrl_reg.parity_en, 1'b0) - 4'h1));
  assign wake_idle = rx_quiet & ctrl_reg.rx_standby & ~ctrl_reg.wake_select; // [R06]
  assign wake_mark = rx_end & ctrl_reg.rx_standby & ctrl_reg.wake_select & rx_sh_reg[8]; // [R06]
  assign idle_set  = rx_quiet & ~ctrl_reg.rx_standby;
  assign rx_take   = rx_end & (~ctrl_reg.rx_standby | wake_mark);

  // Receive sequencer: start check, majority samples, idle line count.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state_reg <= asp_pkg::RX_IDLE;
      rx_ovs_reg   <= '0;
      rx_idx_reg   <= '0;
      rx_ones_reg  <= '0;
      rx_smp_reg   <= '1;
      rx_sh_reg    <= '0;
      rx_noise_reg <= 1'b0;
      rx_armed_reg <= 1'b0;
    end else if (ce_i && !ctrl_reg.rx_enable) begin
      rx_state_reg <= asp_pkg::RX_IDLE;
      rx_ovs_reg   <= '0;
    end else if (ce_i && tick) begin
      rx_ovs_reg <= 4'(rx_ovs_reg + 4'h1);
      case (rx_state_reg)
        asp_pkg::RX_IDLE: begin
          if (!rx_in) begin
            rx_state_reg <= asp_pkg::RX_BITS;
            rx_ovs_reg   <= '0;
            rx_idx_reg   <= '0;
            rx_noise_reg <= 1'b0;
            rx_ones_reg  <= '0;
            rx_armed_reg <= 1'b1;
          end else if (rx_ovs_reg == asp_pkg::OVS_LAST) begin
            if (rx_quiet) rx_armed_reg <= 1'b0;
            if (rx_armed_reg) rx_ones_reg <= 4'(rx_ones_reg + 4'h1);
          end
        end
        asp_pkg::RX_BITS: begin
          if (rx_ovs_reg >= asp_pkg::SMP_FIRST && rx_ovs_reg <= asp_pkg::SMP_LAST) begin
            rx_smp_reg <= {rx_smp_reg[1:0], rx_in};
          end
          if (rx_ovs_reg == asp_pkg::OVS_LAST) begin
            if (rx_smp_reg != 3'h0 && rx_smp_reg != 3'h7) rx_noise_reg <= 1'b1;
            rx_idx_reg <= 4'(rx_idx_reg + 4'h1);
            if ((rx_idx_reg == 4'h0 && rx_maj) || rx_end) begin
              rx_state_reg <= asp_pkg::RX_IDLE;
            end else begin
              rx_sh_reg[rx_idx_reg] <= rx_maj;
            end
          end
        end
        default: rx_state_reg <= asp_pkg::RX_IDLE;
      endcase
    end
  end

  // Data buffers behind the one data address, both cleared by reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_buf_reg <= asp_pkg::DATA_RESET;
      rx_buf_reg <= asp_pkg::DATA_RESET;
    end else if (ce_i) begin
      if (wr && hit(wb_adr_i, asp_pkg::OFS_DATA)) tx_buf_reg <= wb_dat_i[7:0]; // [R18]
      if (rx_take && !stat_reg[asp_pkg::S_RDRF]) rx_buf_reg <= rx_sh_reg[8:1];
    end
  end

  // Clearing sequences: status read arms, then a data access clears.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arm_rx_reg <= 1'b0;
      arm_tx_reg <= 1'b0;
    end else if (ce_i && acc && hit(wb_adr_i, asp_pkg::OFS_STAT_ONE) && !wb_we_i) begin
      arm_rx_reg <= |(stat_reg & asp_pkg::RX_FLAGS);
      arm_tx_reg <= stat_reg[asp_pkg::S_TDRE];
    end else if (ce_i && acc && hit(wb_adr_i, asp_pkg::OFS_DATA)) begin
      if (!wb_we_i) arm_rx_reg <= 1'b0;
      if (wb_we_i) arm_tx_reg <= 1'b0;
    end
  end

  // Next status: clears from the sequences first, hardware sets after.
  always_comb begin
    stat_next = stat_reg;
    if (rd && hit(wb_adr_i, asp_pkg::OFS_DATA) && arm_rx_reg) begin
      stat_next = stat_next & ~asp_pkg::RX_FLAGS; // [R12]
    end
    if (wr && hit(wb_adr_i, asp_pkg::OFS_DATA) && arm_tx_reg) begin
      stat_next[asp_pkg::S_TDRE] = 1'b0; // [R12]
    end
    if (tx_start && !frame_brk && !idle_pend_reg) stat_next[asp_pkg::S_TDRE] = 1'b1;
    if (idle_set) stat_next[asp_pkg::S_IDLE] = 1'b1;
    if (rx_take && stat_reg[asp_pkg::S_RDRF]) stat_next[asp_pkg::S_OR] = 1'b1;
    if (rx_take && !stat_reg[asp_pkg::S_RDRF]) begin
      stat_next[asp_pkg::S_RDRF] = 1'b1;
      if (rx_noise_reg || (rx_smp_reg != 3'h0 && rx_smp_reg != 3'h7)) begin
        stat_next[asp_pkg::S_NF] = 1'b1;
      end
      if (!rx_maj) stat_next[asp_pkg::S_FE] = 1'b1;
      if (ctrl_reg.parity_en && ((^rx_sh_reg[9:1]) != ctrl_reg.parity_odd)) begin
        stat_next[asp_pkg::S_PF] = 1'b1;
      end
    end
    stat_next[asp_pkg::S_TC] = ~tx_busy & ~brk_pend_reg & ~idle_pend_reg &
                               stat_next[asp_pkg::S_TDRE];
  end

  // Status register: bus writes never reach it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_reg <= asp_pkg::STAT_RESET;
    end else if (ce_i) begin
      stat_reg <= stat_next; // [R11]
    end
  end

  // Interrupt request from the enabled error flags.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(stat_reg[asp_pkg::S_OR:asp_pkg::S_PF] & ctrl_reg.irq_en); // [R14] [R15] [R16] [R17] [R22]
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_tx_pin_drive: assert property ( // [R01]
    ce_i && ctrl_reg.tx_enable && !single_wire |=> txd_oe_o)
    else $error("transmit pin not driven while enabled");
  a_single_wire_rx: assert property ( // [R02]
    ce_i && single_wire && !ctrl_reg.single_wire_direction |=> !txd_oe_o)
    else $error("single wire pin driven in receive direction");
  a_idle_queued: assert property ( // [R03]
    ce_i && wr && hit(wb_adr_i, asp_pkg::OFS_CTRL_TWO) && tx_busy && !ctrl_reg.tx_enable &&
    wb_dat_i[asp_pkg::B_TX_EN] |=> idle_pend_reg)
    else $error("idle character not queued on re-enable");
  a_rx_pin_free: assert property ( // [R05]
    ce_i && (!ctrl_reg.rx_enable || ctrl_reg.loop_select) |=> !rxd_own_o)
    else $error("receive pin held while receiver off or looped");
  a_break_length: assert property ( // [R09]
    ce_i && tx_start && frame_brk |=>
    tx_left_reg == 4'(asp_pkg::FRAME_BITS + {3'h0, $past(ctrl_reg.parity_en)} +
                      ($past(ctrl_reg.long_break_select) ? asp_pkg::BRK_EXTRA : 4'h0)))
    else $error("break length wrong");
  a_stat_write_ro: assert property ( // [R11]
    ce_i && wr && hit(wb_adr_i, asp_pkg::OFS_STAT_ONE) && !tx_busy |=>
    (stat_reg & $past(stat_reg) & asp_pkg::RX_FLAGS) == ($past(stat_reg) & asp_pkg::RX_FLAGS))
    else $error("status flag cleared by a status write");
  a_tx_inversion: assert property ( // [R13]
    $past(ce_i) |-> txd_o == (($past(tx_busy) ? $past(tx_sh_reg[0]) : 1'b1) ^
                              $past(ctrl_reg.tx_polarity_flip)))
    else $error("transmit polarity not applied");
  a_irq_request: assert property ( // [R22]
    ce_i && |(stat_reg[asp_pkg::S_OR:asp_pkg::S_PF] & ctrl_reg.irq_en) |=> irq_o)
    else $error("enabled error flag did not raise interrupt");
  a_wake_clears: assert property ( // [R07]
    ce_i && wake_mark && !wr |=> !ctrl_reg.rx_standby)
    else $error("standby not cleared on address mark");
endmodule : asp_core

// ### dv/asp_remote.sv
// Remote serial device that sends frames into the receive pin and catches transmitted ones.
// Assumes a bit time of 16 clocks, so baud divisor 1.
`timescale 1ns/1ps
module asp_remote (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  initial line_o = 1'b1;
  // Sends start, eight bits LSB first and a stop bit, then idles high.
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    @(posedge clk_i);
    for (int i = 0; i < 11; i++) begin
      line_o <= (i < 10) ? f[i] : 1'b1;
      repeat (16) @(posedge clk_i);
    end
  endtask : send
  // Waits for a start bit from the port, then samples each data bit and the stop bit in its middle.
  task automatic catch_frame(output logic [7:0] b, output logic stop);
    int n;
    n = 0;
    while (line_i !== 1'b0 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge clk_i);
      b[i] = line_i;
    end
    repeat (16) @(posedge clk_i);
    stop = line_i;
  endtask : catch_frame
endmodule : asp_remote

// ### dv/tb.sv
// Testbench: Wishbone accesses to the port and frames from the remote model.
// Assumes asp_core on a 4 ns clock with its reset baud divisor of 1.
`timescale 1ns/1ps
module tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        we    = 1'b0;
  logic [3:0]  sel   = 4'h0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat;
  logic [7:0]  rb;
  logic        rs;
  logic [31:0] dat_o;
  logic        ack, rxd, txd, oe, own, irq;
  int          mismatches = 0;
  int          checked    = 0;
  // The clock toggles every half period.
  always #2 clk_i = ~clk_i;
  asp_core uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .rxd_i(rxd), .txd_i(oe ? txd : 1'b1), .txd_o(txd), .txd_oe_o(oe),
    .rxd_own_o(own), .irq_o(irq));
  asp_remote rem (.clk_i(clk_i), .line_i(txd), .line_o(rxd));
  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One classic Wishbone cycle; read data is taken at the ack edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    we   <= w;
    sel  <= 4'hF;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = dat_o;
    cyc  <= 1'b0;
    if (n >= 50) mismatches++;
  endtask : wb
  // Prints the verdict and ends the run.
  task automatic tally_and_finish;
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  // Cuts a hang short.
  initial begin
    #20000;
    mismatches++;
    tally_and_finish();
  end
  // Main sequence of register and line tests.
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({31'h0, oe}, 32'h0);
    wb(1'b0, asp_pkg::OFS_STAT_ONE, 32'h0);
    chk(rdat, {24'h0, asp_pkg::STAT_RESET});
    wb(1'b0, asp_pkg::OFS_DATA, 32'h0);
    chk(rdat, 32'h0);
    wb(1'b1, asp_pkg::OFS_STAT_ONE, 32'hFF);
    wb(1'b0, asp_pkg::OFS_STAT_ONE, 32'h0);
    chk(rdat, {24'h0, asp_pkg::STAT_RESET});
    wb(1'b1, asp_pkg::OFS_CTRL_TWO, 32'h0C);
    repeat (3) @(posedge clk_i);
    chk({30'h0, oe, own}, 32'h3);
    wb(1'b1, asp_pkg::OFS_CTRL_THREE, 32'h12);
    repeat (3) @(posedge clk_i);
    chk({31'h0, txd}, 32'h0);
    wb(1'b1, asp_pkg::OFS_CTRL_THREE, 32'h02);
    rem.send(8'hA5, 1'b1);
    wb(1'b0, asp_pkg::OFS_STAT_ONE, 32'h0);
    chk({31'h0, rdat[5]}, 32'h1);
    wb(1'b0, asp_pkg::OFS_DATA, 32'h0);
    chk(rdat, 32'hA5);
    wb(1'b0, asp_pkg::OFS_STAT_ONE, 32'h0);
    chk({31'h0, rdat[5]}, 32'h0);
    rem.send(8'h3C, 1'b0);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    wb(1'b0, asp_pkg::OFS_STAT_ONE, 32'h0);
    wb(1'b0, asp_pkg::OFS_DATA, 32'h0);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    // Standby on address mark: a char with a clear top bit is skipped.
    wb(1'b1, asp_pkg::OFS_CTRL_ONE, 32'h08);
    wb(1'b1, asp_pkg::OFS_CTRL_TWO, 32'h0E);
    rem.send(8'h15, 1'b1);
    rem.send(8'h95, 1'b1);
    wb(1'b0, asp_pkg::OFS_CTRL_TWO, 32'h0);
    chk(rdat, 32'h0C);
    wb(1'b0, asp_pkg::OFS_DATA, 32'h0);
    chk(rdat, 32'h95);
    // One data frame, then re-enable during it to queue an idle character.
    wb(1'b1, asp_pkg::OFS_DATA, 32'h5A);
    fork
      rem.catch_frame(rb, rs);
      begin
        wb(1'b1, asp_pkg::OFS_CTRL_TWO, 32'h04);
        wb(1'b1, asp_pkg::OFS_CTRL_TWO, 32'h0C);
        wb(1'b1, asp_pkg::OFS_CTRL_TWO, 32'h04);
      end
    join
    chk({24'h0, rb}, 32'h5A);
    chk({31'h0, rs}, 32'h1);
    repeat (100) @(posedge clk_i);
    chk({31'h0, oe}, 32'h1);
    repeat (150) @(posedge clk_i);
    chk({31'h0, oe}, 32'h0);
    // Long break held then cleared: two long breaks back to back.
    wb(1'b1, asp_pkg::OFS_CTRL_ONE, 32'h04);
    wb(1'b1, asp_pkg::OFS_CTRL_TWO, 32'h0D);
    wb(1'b1, asp_pkg::OFS_CTRL_TWO, 32'h0C);
    repeat (367) @(posedge clk_i);
    chk({31'h0, txd}, 32'h0);
    repeat (70) @(posedge clk_i);
    chk({31'h0, txd}, 32'h1);
    // Single wire in receive direction releases both pins.
    wb(1'b1, asp_pkg::OFS_CTRL_ONE, 32'hA0);
    repeat (3) @(posedge clk_i);
    chk({30'h0, oe, own}, 32'h0);
    tally_and_finish();
  end
endmodule : tb
